/* File: rtl/imipr_top.sv */
// imipr_top: interrupt level mask and instruction pointer register bank
// assumes a same-clock register port master and same-clock request sources
//
// Overview of operation
// R01 - eight-bit level mask at DDH, set one
// R02 - mask bit zero masks, one enables; RW
// R03 - masked level requests are never recognized
// R04 - pointer high byte register at DAH, set one
// R05 - pointer low byte register at DBH, set one
// R06 - software initialises all three before use
//
// Added by the designer: the strobed register port.
module imipr_top #(
  parameter int unsigned LEVELS = imipr_pkg::LEVELS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_upper_register_set_one_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [LEVELS-1:0] irq_req,
  input wire logic ip_load,
  input wire logic [15:0] ip_load_value,
  output logic [15:0] ip_value,
  output logic [7:0] interrupt_level_mask,
  output logic [LEVELS-1:0] irq_recognized,
  output logic irq_any
);

  imipr_pkg::imipr_sel_t sel;
  logic wr_ip_high;
  logic wr_ip_low;
  logic wr_mask;
  logic [7:0] ip_high_q;
  logic [7:0] ip_low_q;
  logic [7:0] mask_q;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // decode: the bank only answers inside the upper register set one
  always_comb begin
    sel = imipr_pkg::IMIPR_SEL_NONE;
    if (reg_upper_register_set_one_sel) begin
      unique case (reg_addr)
        imipr_pkg::ADDR_IP_HIGH: begin
          sel = imipr_pkg::IMIPR_SEL_IP_HIGH; // [R04]
        end
        imipr_pkg::ADDR_IP_LOW: begin
          sel = imipr_pkg::IMIPR_SEL_IP_LOW; // [R05]
        end
        imipr_pkg::ADDR_LEVEL_MASK: begin
          sel = imipr_pkg::IMIPR_SEL_MASK; // [R01]
        end
        default: begin
          sel = imipr_pkg::IMIPR_SEL_NONE;
        end
      endcase
    end
  end

  assign wr_ip_high = reg_wr && (sel == imipr_pkg::IMIPR_SEL_IP_HIGH);
  assign wr_ip_low = reg_wr && (sel == imipr_pkg::IMIPR_SEL_IP_LOW);
  assign wr_mask = reg_wr && (sel == imipr_pkg::IMIPR_SEL_MASK);

  // pointer halves; the core may load the whole pointer, a byte write wins
  imipr_byte_reg #(
    .WIDTH(8),
    .RESET_VAL(imipr_pkg::RESET_IP_HIGH)
  ) u_ip_high (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_en(wr_ip_high), // [R04]
    .wr_data(reg_wdata),
    .ld_en(ip_load),
    .ld_data(ip_load_value[imipr_pkg::IP_HIGH_MSB:imipr_pkg::IP_HIGH_LSB]),
    .q(ip_high_q)
  );

  imipr_byte_reg #(
    .WIDTH(8),
    .RESET_VAL(imipr_pkg::RESET_IP_LOW)
  ) u_ip_low (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_en(wr_ip_low), // [R05]
    .wr_data(reg_wdata),
    .ld_en(ip_load),
    .ld_data(ip_load_value[imipr_pkg::IP_LOW_MSB:imipr_pkg::IP_LOW_LSB]),
    .q(ip_low_q)
  );

  // mask has no hardware load: only software changes it
  imipr_byte_reg #(
    .WIDTH(8),
    .RESET_VAL(imipr_pkg::RESET_LEVEL_MASK)
  ) u_mask (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_en(wr_mask), // [R01] [R02]
    .wr_data(reg_wdata),
    .ld_en(1'b0),
    .ld_data(imipr_pkg::RESET_LEVEL_MASK),
    .q(mask_q)
  );

  // reset forces all levels masked, so stray requests stay hidden until set up
  imipr_level_gate #(
    .LEVELS(LEVELS)
  ) u_gate (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .req(irq_req),
    .mask(mask_q[LEVELS-1:0]), // [R03]
    .recognized(irq_recognized),
    .any(irq_any)
  );

  // read data only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_nxt = imipr_pkg::IDLE_RDATA;
    if (reg_rd) begin
      unique case (sel)
        imipr_pkg::IMIPR_SEL_IP_HIGH: begin
          rdata_nxt = ip_high_q; // [R04]
        end
        imipr_pkg::IMIPR_SEL_IP_LOW: begin
          rdata_nxt = ip_low_q; // [R05]
        end
        imipr_pkg::IMIPR_SEL_MASK: begin
          rdata_nxt = mask_q; // [R02]
        end
        imipr_pkg::IMIPR_SEL_NONE: begin
          rdata_nxt = imipr_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= imipr_pkg::RESET_RDATA;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign ip_value = {ip_high_q, ip_low_q};
  assign interrupt_level_mask = mask_q;

  // a mask write with value zero, then one quiet cycle
  sequence seq_mask_all_cleared;
    ce && wr_mask && (reg_wdata == 8'h00);
  endsequence

  sequence seq_quiet_cycle;
    ce && !reg_wr;
  endsequence

  // mask write with all levels enabled while requests stand
  sequence seq_mask_all_enabled;
    ce && wr_mask && (reg_wdata == 8'hFF);
  endsequence

  sequence seq_req_steady;
    ce && !reg_wr && $stable(irq_req);
  endsequence

  property p_mask_write_lands;
    @(posedge clk) disable iff (rst)
      (ce && wr_mask) |=> (interrupt_level_mask == $past(reg_wdata));
  endproperty

  property p_masked_never_seen;
    @(posedge clk) disable iff (rst)
      seq_mask_all_cleared ##1 seq_quiet_cycle |=> (irq_recognized == '0) && !irq_any;
  endproperty

  property p_enabled_passes;
    @(posedge clk) disable iff (rst)
      seq_mask_all_enabled ##1 seq_req_steady |=> (irq_recognized == $past(irq_req));
  endproperty

  AST_MASK_WRITE: assert property (p_mask_write_lands) // [R01]
    else $error("mask write did not reach the mask register");

  AST_MASK_READBACK: assert property ( // [R02]
    @(posedge clk) disable iff (rst)
      (ce && reg_rd && (sel == imipr_pkg::IMIPR_SEL_MASK)) |=> (reg_rdata == $past(mask_q)))
    else $error("mask read returned wrong value");

  AST_MASKED_HIDDEN: assert property (p_masked_never_seen) // [R03]
    else $error("request recognized on a masked level");

  AST_NO_RECOG_OUTSIDE_MASK: assert property ( // [R03]
    @(posedge clk) disable iff (rst)
      ce |=> ((irq_recognized & ~$past(mask_q[LEVELS-1:0])) == '0))
    else $error("recognized level whose mask bit was clear");

  AST_UNMASKED_SEEN: assert property (p_enabled_passes) // [R02]
    else $error("enabled level request not recognized");

  AST_ANY_MATCHES: assert property (
    @(posedge clk) disable iff (rst)
      irq_any == (|irq_recognized))
    else $error("summary request flag disagrees with levels");

  AST_IP_HIGH_WRITE: assert property ( // [R04]
    @(posedge clk) disable iff (rst)
      (ce && wr_ip_high) |=> (ip_value[15:8] == $past(reg_wdata)) && $stable(ip_value[7:0]) || $past(ip_load))
    else $error("pointer high byte write failed");

  AST_IP_LOW_READ: assert property ( // [R05]
    @(posedge clk) disable iff (rst)
      (ce && wr_ip_low) ##1 (ce && reg_rd && (sel == imipr_pkg::IMIPR_SEL_IP_LOW))
        |=> (reg_rdata == $past(reg_wdata, 2)))
    else $error("pointer low byte did not read back");

  AST_IP_LOAD: assert property ( // [R04]
    @(posedge clk) disable iff (rst)
      (ce && ip_load && !reg_wr) |=> (ip_value == $past(ip_load_value)))
    else $error("pointer hardware load failed");

  AST_OTHER_SET_IGNORED: assert property ( // [R01]
    @(posedge clk) disable iff (rst)
      (ce && reg_wr && !reg_upper_register_set_one_sel) |=> $stable(interrupt_level_mask))
    else $error("mask changed by write outside set one");

  AST_UNMAPPED_READ: assert property (
    @(posedge clk) disable iff (rst)
      (ce && reg_rd && (sel == imipr_pkg::IMIPR_SEL_NONE)) |=> (reg_rdata == imipr_pkg::UNMAPPED_READ))
    else $error("unmapped read not zero");

  AST_RDATA_IDLE: assert property (
    @(posedge clk) disable iff (rst)
      (ce && !reg_rd) |=> (reg_rdata == imipr_pkg::IDLE_RDATA))
    else $error("read data left standing without a read");

  AST_FREEZE: assert property (
    @(posedge clk) disable iff (rst)
      !ce |=> $stable(ip_value) && $stable(interrupt_level_mask) && $stable(reg_rdata))
    else $error("state moved while clock enable low");

  // a byte write and a core load in one cycle: the written byte wins
  sequence seq_load_with_high_write;
    ce && ip_load && wr_ip_high;
  endsequence

  AST_WRITE_BEATS_LOAD: assert property ( // [R04]
    @(posedge clk) disable iff (rst)
      seq_load_with_high_write |=> (ip_value[15:8] == $past(reg_wdata)) &&
        (ip_value[7:0] == $past(ip_load_value[7:0])))
    else $error("pointer load overrode a byte write");

  AST_IP_LOW_WRITE: assert property ( // [R05]
    @(posedge clk) disable iff (rst)
      (ce && wr_ip_low) |=> (ip_value[7:0] == $past(reg_wdata)))
    else $error("pointer low byte write failed");

  AST_IP_HIGH_READ: assert property ( // [R04]
    @(posedge clk) disable iff (rst)
      (ce && reg_rd && (sel == imipr_pkg::IMIPR_SEL_IP_HIGH)) |=> (reg_rdata == $past(ip_high_q)))
    else $error("pointer high byte read returned wrong value");

  AST_RECOG_LATE: assert property ( // [R03]
    @(posedge clk) disable iff (rst)
      ce |=> (irq_recognized == ($past(irq_req) & $past(mask_q[LEVELS-1:0]))))
    else $error("recognized levels not the masked requests of the cycle before");

  AST_ANY_LATE: assert property ( // [R03]
    @(posedge clk) disable iff (rst)
      ce |=> (irq_any == (|($past(irq_req) & $past(mask_q[LEVELS-1:0])))))
    else $error("summary request flag wrong after a cycle");

  AST_MASK_ONLY_BY_WRITE: assert property ( // [R02]
    @(posedge clk) disable iff (rst)
      !(ce && wr_mask) |=> $stable(interrupt_level_mask))
    else $error("mask changed without a mask write");

  AST_OTHER_SET_PTR: assert property ( // [R04] [R05]
    @(posedge clk) disable iff (rst)
      (ce && reg_wr && !reg_upper_register_set_one_sel && !ip_load) |=> $stable(ip_value))
    else $error("pointer changed by write outside set one");

  AST_FREEZE_RECOG: assert property (
    @(posedge clk) disable iff (rst)
      !ce |=> $stable(irq_recognized) && $stable(irq_any))
    else $error("request levels moved while clock enable low");

  // reset does not wait for the clock enable
  AST_RESET_CLEARS: assert property (
    @(posedge clk)
      rst |=> (interrupt_level_mask == imipr_pkg::RESET_LEVEL_MASK) && (reg_rdata == imipr_pkg::RESET_RDATA) &&
        (ip_value == {imipr_pkg::RESET_IP_HIGH, imipr_pkg::RESET_IP_LOW}) && (irq_recognized == '0) && !irq_any)
    else $error("reset did not clear the bank");

endmodule

/* File: rtl/imipr_pkg.sv */
// imipr_pkg: constants and types for the interrupt mask and instruction pointer bank
// assumes byte-wide register space with a separate upper set select
package imipr_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned LEVELS = 8;
  localparam int unsigned IP_W = 16;

  // register addresses inside the upper register set one
  localparam logic [7:0] ADDR_IP_HIGH = 8'hDA;
  localparam logic [7:0] ADDR_IP_LOW = 8'hDB;
  localparam logic [7:0] ADDR_LEVEL_MASK = 8'hDD;

  // field positions of the pointer halves
  localparam int unsigned IP_HIGH_MSB = 15;
  localparam int unsigned IP_HIGH_LSB = 8;
  localparam int unsigned IP_LOW_MSB = 7;
  localparam int unsigned IP_LOW_LSB = 0;

  // mask bit meaning
  localparam logic MASK_BIT_MASKED = 1'b0;
  localparam logic MASK_BIT_ENABLED = 1'b1;

  // reset values: documented as undefined, held at a known safe value here
  localparam logic [7:0] RESET_IP_HIGH = 8'h00;
  localparam logic [7:0] RESET_IP_LOW = 8'h00;
  localparam logic [7:0] RESET_LEVEL_MASK = 8'h00;
  localparam logic [7:0] RESET_RDATA = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] IDLE_RDATA = 8'h00;

  typedef enum logic [1:0] {
    IMIPR_SEL_NONE = 2'b00,
    IMIPR_SEL_IP_HIGH = 2'b01,
    IMIPR_SEL_IP_LOW = 2'b10,
    IMIPR_SEL_MASK = 2'b11
  } imipr_sel_t;

endpackage

/* File: rtl/imipr_byte_reg.sv */
// imipr_byte_reg: one software register with an optional hardware load
// assumes write and load come from logic on the same clock
module imipr_byte_reg #(
  parameter int unsigned WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic ld_en,
  input wire logic [WIDTH-1:0] ld_data,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] val_r;
  logic [WIDTH-1:0] val_nxt;

  // software write beats a hardware load in the same cycle
  always_comb begin
    val_nxt = val_r;
    if (wr_en) begin
      val_nxt = wr_data;
    end else if (ld_en) begin
      val_nxt = ld_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      val_r <= RESET_VAL;
    end else if (ce) begin
      val_r <= val_nxt;
    end
  end

  assign q = val_r;

endmodule

/* File: rtl/imipr_level_gate.sv */
// imipr_level_gate: gates raw interrupt requests by the level mask
// assumes requests are levels from logic on the same clock
module imipr_level_gate #(
  parameter int unsigned LEVELS = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [LEVELS-1:0] req,
  input wire logic [LEVELS-1:0] mask,
  output logic [LEVELS-1:0] recognized,
  output logic any
);

  logic [LEVELS-1:0] rec_r;
  logic [LEVELS-1:0] rec_nxt;
  logic any_r;
  logic any_nxt;

  // a clear mask bit hides the level whatever raises it [R03]
  always_comb begin
    rec_nxt = req & mask;
    any_nxt = |rec_nxt;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rec_r <= '0;
      any_r <= 1'b0;
    end else if (ce) begin
      rec_r <= rec_nxt;
      any_r <= any_nxt;
    end
  end

  assign recognized = rec_r;
  assign any = any_r;

endmodule

/* File: verification/imipr_core_model.sv */
// imipr_core_model: core side that raises level requests and loads the pointer
// assumes bench commands arrive on the same clock
module imipr_core_model (
  input wire logic clk,
  input wire logic [7:0] cmd_req,
  input wire logic cmd_load,
  input wire logic [15:0] cmd_val,
  output logic [7:0] irq_req,
  output logic ip_load,
  output logic [15:0] ip_load_value
);
  timeunit 1ns;
  timeprecision 1ps;
  // one driver per output; irq_req and ip_load unknown only until the first edge, inside reset; ip_load_value until the first load
  always @(posedge clk) begin
    irq_req <= cmd_req;
    ip_load <= cmd_load;
    // stale outside a load, so invert the held value every cycle
    ip_load_value <= cmd_load ? cmd_val : ~ip_load_value;
  end
endmodule

/* File: verification/imipr_bench.sv */
// imipr_bench: self-checking bench for the mask and pointer bank
// assumes imipr_top and the core model on one 25 MHz clock
module imipr_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } imipr_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic upper_register_set_one = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cload = 1'b0;
  logic any;
  logic ip_load;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] creq = 8'h00;
  logic [7:0] rdata, mask, recog, irq_req, v;
  logic [15:0] cval = 16'h0000;
  logic [15:0] ip_value, ip_ldv;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  // unmapped rows read back as zero
  imipr_row_t rows [5] = '{'{8'hDA, 8'h5A, 8'h5A}, '{8'hDB, 8'hC3, 8'hC3},
    '{8'hDD, 8'hA5, 8'hA5}, '{8'hDC, 8'hFF, 8'h00}, '{8'hDE, 8'h11, 8'h00}};

  imipr_top i_imipr_top (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr), .reg_upper_register_set_one_sel(upper_register_set_one),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq_req(irq_req),
    .ip_load(ip_load), .ip_load_value(ip_ldv), .ip_value(ip_value),
    .interrupt_level_mask(mask), .irq_recognized(recog), .irq_any(any));
  imipr_core_model i_imipr_core_model (.clk(clk), .cmd_req(creq), .cmd_load(cload),
    .cmd_val(cval), .irq_req(irq_req), .ip_load(ip_load), .ip_load_value(ip_ldv));

  always #20 clk = ~clk;

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // write then read with no gap between the strobes
  task automatic wr_rd_reg(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ceiling well above the roughly 120 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'hDD, v);
    chk("reset mask", {8'h00, v}, 16'h0000);
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, v);
      chk("readback", {8'h00, v}, {8'h00, rows[i].e});
    end
    chk("pointer", ip_value, 16'h5AC3);
    chk("mask port", {8'h00, mask}, 16'h00A5);
    // other register set must not reach the mask
    @(posedge clk);
    upper_register_set_one <= 1'b0;
    wr_reg(8'hDD, 8'h00);
    upper_register_set_one <= 1'b1;
    rd_reg(8'hDD, v);
    chk("set select", {8'h00, v}, 16'h00A5);
    @(posedge clk);
    #1 chk("rdata one cycle", {8'h00, rdata}, 16'h0000);
    @(posedge clk);
    creq <= 8'hFF;
    for (int n = 0; n < 8; n++) begin
      wr_reg(8'hDD, 8'h01 << n);
      repeat (3) @(posedge clk);
      #1 chk("recognized", {7'h00, any, recog}, {7'h00, 1'b1, 8'h01 << n});
    end
    wr_reg(8'hDD, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk("all masked", {7'h00, any, recog}, 16'h0000);
    @(posedge clk);
    creq <= 8'h03;
    wr_reg(8'hDD, 8'hFE);
    repeat (3) @(posedge clk);
    #1 chk("partial", {7'h00, any, recog}, 16'h0102);
    @(posedge clk);
    cval <= 16'h1234;
    cload <= 1'b1;
    @(posedge clk);
    cload <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("pointer load", ip_value, 16'h1234);
    rd_reg(8'hDA, v);
    chk("high byte", {8'h00, v}, 16'h0012);
    // frozen clock enable must drop the write
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(8'hDD, 8'h00);
    ce <= 1'b1;
    rd_reg(8'hDD, v);
    chk("ce freeze", {8'h00, v}, 16'h00FE);
    // second reset in mid-run, requests still standing
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("reset pointer", ip_value, 16'h0000);
    chk("reset mask port", {8'h00, mask}, 16'h0000);
    chk("reset levels", {7'h00, any, recog}, 16'h0000);
    chk("reset rdata", {8'h00, rdata}, 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'hDD, v);
    chk("mask after reset", {8'h00, v}, 16'h0000);
    wr_reg(8'hDD, 8'hFF);
    repeat (3) @(posedge clk);
    #1 chk("all enabled", {7'h00, any, recog}, 16'h0103);
    wr_rd_reg(8'hDB, 8'h3C, v);
    chk("back to back", {8'h00, v}, 16'h003C);
    chk("pointer after reset", ip_value, 16'h003C);
    // core load and byte write in one cycle
    @(posedge clk);
    cval <= 16'hBEEF;
    cload <= 1'b1;
    @(posedge clk);
    cload <= 1'b0;
    addr <= 8'hDA;
    wdata <= 8'h77;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("write beats load", ip_value, 16'h77EF);
    finish_test();
  end
endmodule
